// file: rtl/deg_pkg.sv
// Purpose: shared types and constants for the dual-edge pad logic
// Assumes: one system clock; core-side clocks arrive as sampled levels
// Notes:   configuration word layout is fixed by deg_cfg_s
package deg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;

  // ----------------------------------------------------------------
  // pin input synchroniser
  // ----------------------------------------------------------------
  localparam int          SYNC_LEN   = 3;

  typedef enum logic [1:0] {
    DEG_PULL_NONE = 2'b00,
    DEG_PULL_UP   = 2'b01,
    DEG_PULL_DOWN = 2'b10,
    DEG_PULL_KEEP = 2'b11
  } deg_pull_e;

  // ----------------------------------------------------------------
  // control word, bit 0 is in_reg
  // ----------------------------------------------------------------
  typedef struct packed {
    deg_pull_e pull;       // [11:10]
    logic      lvds;       // [9] pin built on differential pair
    logic      out_inv;    // [8]
    logic      oe_fall;    // [7]
    logic      out_fall;   // [6]
    logic      in_fall;    // [5]
    logic      resync;     // [4]
    logic      dual_edge;  // [3]
    logic      oe_reg;     // [2]
    logic      out_reg;    // [1]
    logic      in_reg;     // [0]
  } deg_cfg_s;

  localparam int          CFG_W      = $bits(deg_cfg_s);
  localparam logic [11:0] CFG_RESET  = 12'h000;

  // core-side bit pair, bit 0 is the primary one
  typedef struct packed {
    logic late_bit;
    logic primary_bit;
  } deg_pair_s;

  typedef struct packed {
    logic [SYNC_LEN-1:0] stage;
    logic                level;
  } deg_sync_s;

endpackage

// file: rtl/deg_pin_sync.sv
// Purpose: bring an outside level onto the system clock
// Assumes: pin may change at any time relative to clk
// Notes:   level moves only once the last two stages agree
`timescale 1ns/1ps
module deg_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and filtered level
  input  wire logic pin,
  output logic      level
);

  deg_pkg::deg_sync_s st;
  deg_pkg::deg_sync_s next_st;

  // ----------------------------------------------------------------
  // shift chain; first stage feeds only the second
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.stage = {st.stage[deg_pkg::SYNC_LEN-2:0], pin};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;

endmodule

// file: rtl/deg_gpio_top.sv
// Purpose: per-pin input, output and enable logic with dual-edge paths
// Assumes: launch and sample clocks are slow levels, sampled on MCLK
// Notes:   all pad and core outputs are registered once on MCLK
`timescale 1ns/1ps
// What this block does
// - input bus two bits, bit 0 single-rate
// - dual-edge: rising to bit 0, falling to bit 1
// - core drives two output bits, bit 0 ordinary
// - unregistered input gives bypass tap from pad
// - core enable drives pad, optionally registered
// - output and enable registers use launch clock
// - input registers use separate sample clock
// - dual-edge registers both edges, both directions
// - two bits per clock cycle in dual-edge
// - normal mode: each bit on own edge
// - resync mode: both bits on rising edge
// - resync input delays falling bit half period
// - differential-pair pin has no dual-edge
// - differential-pair pin has no pull-down
// - each register picks rising or falling edge
// - registered output may be inverted
// - input and output registered independently
module deg_gpio_top (
  // system
  input  wire logic                        MCLK,
  input  wire logic                        SYS_RST,
  // register port
  input  wire logic [deg_pkg::ADDR_W-1:0]  REG_ADDR,
  input  wire logic [deg_pkg::DATA_W-1:0]  REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [deg_pkg::DATA_W-1:0]  REG_RDATA,
  // core side
  input  wire deg_pkg::deg_pair_s          TX_BITS,
  input  wire logic                        CORE_OE,
  output deg_pkg::deg_pair_s               RX_BITS,
  output logic                             BYPASS_TAP,
  // clocks from the core clock tree
  input  wire logic                        LAUNCH_CLOCK,
  input  wire logic                        SAMPLE_CLOCK,
  // pad
  input  wire logic                        PAD_I,
  output logic                             PAD_O,
  output logic                             PAD_OE,
  output logic                             PULL_UP,
  output logic                             PULL_DOWN
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    deg_pkg::deg_cfg_s          cfg;
    logic                       sclk_prev;
    logic                       lclk_prev;
    deg_pkg::deg_pair_s         rx;
    logic                       fall_hold;
    logic                       hi;
    logic                       lo;
    logic                       oe_q;
    logic                       pad_o;
    logic                       pad_oe;
    logic                       tap;
    logic                       pu;
    logic                       pd;
    logic [deg_pkg::DATA_W-1:0] rdata;
  } deg_state_s;

  deg_state_s st;
  deg_state_s next_st;

  logic pad_lvl;
  logic sclk_lvl;
  logic lclk_lvl;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  deg_pin_sync u_pad_sync (
    .clk   (MCLK),
    .rst   (SYS_RST),
    .pin   (PAD_I),
    .level (pad_lvl)
  );

  deg_pin_sync u_sclk_sync (
    .clk   (MCLK),
    .rst   (SYS_RST),
    .pin   (SAMPLE_CLOCK),
    .level (sclk_lvl)
  );

  deg_pin_sync u_lclk_sync (
    .clk   (MCLK),
    .rst   (SYS_RST),
    .pin   (LAUNCH_CLOCK),
    .level (lclk_lvl)
  );

  // ----------------------------------------------------------------
  // edge decode
  // ----------------------------------------------------------------
  function automatic logic pick_edge(input logic rise, input logic fall,
                                     input logic use_fall);
    pick_edge = use_fall ? fall : rise;
  endfunction

  logic s_rise;
  logic s_fall;
  logic l_rise;
  logic l_fall;
  logic de;

  assign s_rise = sclk_lvl & ~st.sclk_prev;
  assign s_fall = ~sclk_lvl & st.sclk_prev;
  assign l_rise = lclk_lvl & ~st.lclk_prev;
  assign l_fall = ~lclk_lvl & st.lclk_prev;
  // dual-edge is never active on a differential-pair pin
  assign de     = st.cfg.dual_edge & ~st.cfg.lvds;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic launched;

  always_comb begin
    next_st           = st;
    launched          = 1'b0;
    next_st.sclk_prev = sclk_lvl;
    next_st.lclk_prev = lclk_lvl;

    // input path
    if (!st.cfg.in_reg) begin
      next_st.rx.primary_bit = pad_lvl;
      next_st.rx.late_bit    = 1'b0;
      next_st.tap            = pad_lvl;
    end else begin
      next_st.tap = 1'b0;
      if (!de) begin
        if (pick_edge(s_rise, s_fall, st.cfg.in_fall)) begin
          next_st.rx.primary_bit = pad_lvl;
          next_st.rx.late_bit    = 1'b0;
        end
      end else if (!st.cfg.resync) begin
        if (s_rise) begin
          next_st.rx.primary_bit = pad_lvl;
        end
        if (s_fall) begin
          next_st.rx.late_bit = pad_lvl;
        end
      end else begin
        if (s_fall) begin
          next_st.fall_hold = pad_lvl;
        end
        if (s_rise) begin
          next_st.rx.primary_bit = pad_lvl;
          next_st.rx.late_bit    = st.fall_hold;
        end
      end
    end

    // output registers, independent of the input path
    if (st.cfg.out_reg) begin
      if (!de) begin
        if (pick_edge(l_rise, l_fall, st.cfg.out_fall)) begin
          next_st.hi = TX_BITS.primary_bit;
        end
      end else if (!st.cfg.resync) begin
        if (l_rise) begin
          next_st.hi = TX_BITS.primary_bit;
        end
        if (l_fall) begin
          next_st.lo = TX_BITS.late_bit;
        end
      end else if (l_rise) begin
        next_st.hi = TX_BITS.primary_bit;
        next_st.lo = TX_BITS.late_bit;
        launched   = 1'b1;
      end
    end

    // pad data
    if (!st.cfg.out_reg) begin
      next_st.pad_o = TX_BITS.primary_bit;
    end else if (de) begin
      next_st.pad_o = (lclk_lvl ? st.hi : st.lo) ^ st.cfg.out_inv;
    end else begin
      next_st.pad_o = st.hi ^ st.cfg.out_inv;
    end

    // output enable
    if (st.cfg.oe_reg
        && pick_edge(l_rise, l_fall, st.cfg.oe_fall)) begin
      next_st.oe_q = CORE_OE;
    end
    next_st.pad_oe = st.cfg.oe_reg ? st.oe_q : CORE_OE;

    // pull resistors
    next_st.pu = (st.cfg.pull == deg_pkg::DEG_PULL_UP);
    next_st.pd = (st.cfg.pull == deg_pkg::DEG_PULL_DOWN)
                 & ~st.cfg.lvds;

    // register port
    if (REG_WR && REG_ADDR == deg_pkg::REG_CTRL) begin
      next_st.cfg = deg_pkg::deg_cfg_s'(REG_WDATA[deg_pkg::CFG_W-1:0]);
    end
    next_st.rdata = '0;
    if (REG_RD) begin
      unique case (REG_ADDR)
        deg_pkg::REG_CTRL: begin
          next_st.rdata[deg_pkg::CFG_W-1:0] = st.cfg;
        end
        deg_pkg::REG_STATUS: begin
          next_st.rdata[7:0] = {launched, de, st.pd, st.pu, st.pad_oe,
                                st.pad_o, st.rx};
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st     <= '0;
      st.cfg <= deg_pkg::deg_cfg_s'(deg_pkg::CFG_RESET);
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign REG_RDATA  = st.rdata;
  assign RX_BITS    = st.rx;
  assign BYPASS_TAP = st.tap;
  assign PAD_O      = st.pad_o;
  assign PAD_OE     = st.pad_oe;
  assign PULL_UP    = st.pu;
  assign PULL_DOWN  = st.pd;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rx_single_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && !de && !st.cfg.in_fall && s_rise)
      |=> (RX_BITS.primary_bit == $past(pad_lvl)) && !RX_BITS.late_bit)
    else $error("single-rate input not captured on rising edge");

  rx_rise_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && de && !st.cfg.resync && s_rise)
      |=> RX_BITS.primary_bit == $past(pad_lvl))
    else $error("rising sample missing on bit 0");

  rx_fall_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && de && !st.cfg.resync && s_fall)
      |=> RX_BITS.late_bit == $past(pad_lvl))
    else $error("falling sample missing on bit 1");

  rx_resync_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && de && st.cfg.resync && s_rise)
      |=> RX_BITS.late_bit == $past(st.fall_hold)
          && RX_BITS.primary_bit == $past(pad_lvl))
    else $error("resync falling bit not delivered at rise");

  bypass_tap_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    st.cfg.in_reg |=> !BYPASS_TAP)
    else $error("bypass tap active with input register");

  oe_direct_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !st.cfg.oe_reg |=> PAD_OE == $past(CORE_OE))
    else $error("unregistered enable not passed");

  lvds_single_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && st.cfg.lvds && !st.cfg.in_fall && s_fall)
      |=> $stable(RX_BITS))
    else $error("dual-edge capture on differential pin");

  no_pulldown_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    st.cfg.lvds |=> !PULL_DOWN)
    else $error("pull-down on differential pin");

  pad_phase_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.out_reg && de && !lclk_lvl)
      |=> PAD_O == ($past(st.lo) ^ $past(st.cfg.out_inv)))
    else $error("low phase does not drive falling bit");

  out_invert_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.out_reg && !de && st.cfg.out_inv)
      |=> PAD_O == !$past(st.hi))
    else $error("output inversion not applied");

  fall_capture_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && de && st.cfg.resync && s_fall)
      |=> st.fall_hold == $past(pad_lvl))
    else $error("resync falling sample not held");

  resync_hold_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.in_reg && de && st.cfg.resync && !s_rise)
      |=> $stable(RX_BITS))
    else $error("resync input changed away from rising edge");

  tap_follow_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !st.cfg.in_reg |=> BYPASS_TAP == $past(pad_lvl))
    else $error("bypass tap does not follow pad");

  rx_direct_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !st.cfg.in_reg
      |=> RX_BITS.primary_bit == $past(pad_lvl) && !RX_BITS.late_bit)
    else $error("unregistered input not passed to core");

  pad_direct_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !st.cfg.out_reg |=> PAD_O == $past(TX_BITS.primary_bit))
    else $error("unregistered output not passed to pad");

  oe_capture_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.oe_reg && (st.cfg.oe_fall ? l_fall : l_rise))
      ##1 st.cfg.oe_reg |=> PAD_OE == $past(CORE_OE, 2))
    else $error("registered enable not launched");

  oe_held_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.oe_reg && !l_rise && !l_fall)
      ##1 st.cfg.oe_reg |=> $stable(PAD_OE))
    else $error("registered enable moved without launch edge");

  out_launch_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    (st.cfg.out_reg && !de && !st.cfg.out_fall && l_rise)
      ##1 $stable(st.cfg)
      |=> PAD_O == ($past(TX_BITS.primary_bit, 2) ^ $past(st.cfg.out_inv)))
    else $error("registered output not launched on rise");

  rdata_idle_a: assert property (
    @(posedge MCLK) disable iff (SYS_RST)
    !REG_RD |=> REG_RDATA == '0)
    else $error("read data not cleared without read strobe");

endmodule

// file: testbench/deg_core_model.sv
// Purpose: core-side user logic driving data, enable and both clocks
// Assumes: each clock phase lasts PH cycles of MCLK
// Notes:   clocks stand still between calls
`timescale 1ns/1ps
module deg_core_model (
  // system
  input  wire logic          mclk,
  // core outputs
  output deg_pkg::deg_pair_s tx_bits,
  output logic               core_oe,
  output logic               launch_clock,
  output logic               sample_clock
);
  localparam int PH = 10;

  initial begin
    tx_bits = 2'b00;
    core_oe = 1'b0;
    launch_clock = 1'b0;
    sample_clock = 1'b0;
  end

  // long phases so the three-flop sync always settles
  task automatic hold();
    repeat (PH) @(posedge mclk);
  endtask

  task automatic drive(input deg_pkg::deg_pair_s b, input logic oe);
    @(posedge mclk);
    tx_bits <= b;
    core_oe <= oe;
  endtask

  task automatic sclk(input logic lv);
    @(posedge mclk);
    sample_clock <= lv;
    hold();
  endtask

  task automatic lclk(input logic lv);
    @(posedge mclk);
    launch_clock <= lv;
    hold();
  endtask
endmodule

// file: testbench/test_dual_edge_gpio_io_logic.sv
// Purpose: self-checking bench for the dual-edge pad logic
// Assumes: core model holds each clock phase for ten MCLK cycles
// Notes:   checks made at the end of each settled phase
`timescale 1ns/1ps
module test_dual_edge_gpio_io_logic;
  logic               mclk = 1'b0;
  logic               sys_rst;
  logic [7:0]         addr;
  logic [31:0]        wdata;
  logic               wr_en;
  logic               rd_en;
  logic               pad_i;
  logic [31:0]        rdata, d;
  deg_pkg::deg_pair_s tx, rx;
  logic               core_oe, lclk_l, sclk_l, tap;
  logic               pad_o, pad_oe, pu, pd;
  logic [15:0]        lf = 16'h6fec;
  logic [15:0]        v;
  logic               el, ep, held;
  logic [1:0]         eo;
  int                 errors = 0;
  int                 tests_run = 0;

  always #5 mclk = ~mclk;

  deg_gpio_top dut (.MCLK(mclk), .SYS_RST(sys_rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr_en), .REG_RD(rd_en), .REG_RDATA(rdata),
    .TX_BITS(tx), .CORE_OE(core_oe), .RX_BITS(rx), .BYPASS_TAP(tap),
    .LAUNCH_CLOCK(lclk_l), .SAMPLE_CLOCK(sclk_l), .PAD_I(pad_i),
    .PAD_O(pad_o), .PAD_OE(pad_oe), .PULL_UP(pu), .PULL_DOWN(pd));
  deg_core_model core (.mclk(mclk), .tx_bits(tx), .core_oe(core_oe),
    .launch_clock(lclk_l), .sample_clock(sclk_l));

  function automatic logic [15:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    chk_reg({30'h0, got}, {30'h0, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= dt;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic setcfg(input logic [11:0] c);
    wr(deg_pkg::REG_CTRL, {20'h0, c});
  endtask

  task automatic pad(input logic x);
    @(posedge mclk);
    pad_i <= x;
    core.hold();
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // run takes some 900 cycles; allow about eleven times that
  initial begin
    #100000;
    errors++;
    summarize();
  end

  // ----
  // tests
  // ----
  initial begin
    sys_rst <= 1'b1;
    addr <= 8'h00;
    wdata <= 32'h0;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    pad_i <= 1'b0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(deg_pkg::REG_CTRL);
    chk_reg(d, {20'h0, deg_pkg::CFG_RESET});
    v = rnd();
    wr(deg_pkg::REG_CTRL, {16'hffff, v});
    rd(deg_pkg::REG_CTRL);
    chk_reg(d, {20'h0, v[11:0]});
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08);
    chk_reg(d, 32'h0);
    rd(deg_pkg::REG_CTRL);
    chk_reg(d, {20'h0, v[11:0]});
    done("regs");
    setcfg(12'h000);
    repeat (6) begin
      v = rnd();
      core.drive(v[2:1], v[3]);
      pad_i <= v[0];
      core.hold();
      chk_pin({tap, rx.primary_bit}, {2{v[0]}});
      chk_pin(rx, {1'b0, v[0]});
      chk_pin({pad_oe, pad_o}, {v[3], v[1]});
    end
    rd(deg_pkg::REG_STATUS);
    chk_reg({28'h0, d[3:0]}, {28'h0, v[3], v[1], 1'b0, v[0]});
    done("bypass");
    for (int f = 0; f < 2; f++) begin
      setcfg(f[0] ? 12'h021 : 12'h001);
      v = rnd();
      core.sclk(f[0]);
      pad(v[0]);
      core.sclk(!f[0]);
      core.drive(v[2:1], 1'b1);
      pad_i <= !v[0];
      core.hold();
      chk_pin(rx, {1'b0, v[0]});
      chk_pin({tap, pad_o}, {1'b0, v[1]});
    end
    done("in_reg");
    el = 1'b0;
    held = 1'b0;
    for (int r = 0; r < 2; r++) begin
      setcfg(r[0] ? 12'h019 : 12'h009);
      for (int i = 0; i < 3; i++) begin
        v = rnd();
        pad(v[0]);
        core.sclk(1'b1);
        ep = v[0];
        if (r) el = held;
        if (r == 0 || i > 0) chk_pin(rx, {el, ep});
        pad(v[1]);
        core.sclk(1'b0);
        if (r) held = v[1]; else el = v[1];
        if (r == 0 || i > 0) chk_pin(rx, {el, ep});
      end
    end
    setcfg(12'h209);
    pad(v[2]);
    core.sclk(1'b1);
    pad(!v[2]);
    core.sclk(1'b0);
    chk_pin(rx, {1'b0, v[2]});
    rd(deg_pkg::REG_STATUS);
    chk_reg({29'h0, d[6], d[1:0]}, {31'h0, v[2]});
    done("dual_in");
    for (int n = 0; n < 2; n++) begin
      setcfg(n[0] ? 12'h1c6 : 12'h006);
      for (int i = 0; i < 3; i++) begin
        v = rnd();
        core.drive(v[1:0], v[2]);
        core.hold();
        if (i > 0) chk_pin({pad_oe, pad_o}, eo);
        core.lclk(1'b1);
        if (!n[0]) eo = {v[2], v[0]};
        if (!n[0] || i > 0) chk_pin({pad_oe, pad_o}, eo);
        core.lclk(1'b0);
        eo = {v[2], v[0] ^ n[0]};
        chk_pin({pad_oe, pad_o}, eo);
      end
    end
    done("out_reg");
    for (int r = 0; r < 2; r++) begin
      setcfg(r[0] ? 12'h01a : 12'h00a);
      repeat (2) begin
        v = rnd();
        core.drive(v[1:0], 1'b1);
        core.lclk(1'b1);
        chk_pin({1'b0, pad_o}, {1'b0, v[0]});
        core.drive(v[3:2], 1'b1);
        core.lclk(1'b0);
        chk_pin({1'b0, pad_o}, {1'b0, r[0] ? v[1] : v[3]});
      end
    end
    done("dual_out");
    for (int k = 0; k < 8; k++) begin
      setcfg({k[1:0], k[2], 9'h000});
      core.hold();
      chk_pin({pd, pu}, {k[1:0] == 2'b10 && !k[2], k[1:0] == 2'b01});
    end
    done("pulls");
    summarize();
  end
endmodule
